// File: include/rcc_pkg.sv
package rcc_pkg;
  // system clock rate, used to turn times into cycle counts
  localparam int unsigned RCC_CLK_KHZ = 25000;
  // internal reset durations in milliseconds
  localparam int unsigned RCC_T_25MS = 25;
  localparam int unsigned RCC_T_200MS = 200;
  localparam int unsigned RCC_T_100MS = 100;
  localparam int unsigned RCC_T_50MS = 50;
  localparam int unsigned RCC_T_16MS = 16;
  localparam int unsigned RCC_T_8MS = 8;
  localparam int unsigned RCC_T_4MS = 4;
  // the same durations as clock cycles
  localparam int unsigned RCC_CYC_25MS = RCC_T_25MS * RCC_CLK_KHZ;
  localparam int unsigned RCC_CYC_200MS = RCC_T_200MS * RCC_CLK_KHZ;
  localparam int unsigned RCC_CYC_100MS = RCC_T_100MS * RCC_CLK_KHZ;
  localparam int unsigned RCC_CYC_50MS = RCC_T_50MS * RCC_CLK_KHZ;
  localparam int unsigned RCC_CYC_16MS = RCC_T_16MS * RCC_CLK_KHZ;
  localparam int unsigned RCC_CYC_8MS = RCC_T_8MS * RCC_CLK_KHZ;
  localparam int unsigned RCC_CYC_4MS = RCC_T_4MS * RCC_CLK_KHZ;
  // duration counter width, holds the 200 ms count
  localparam int unsigned RCC_CNT_W = 23;
  // special function register addresses
  localparam logic [7:0] RCC_ADDR_INTERFACE_CTRL_REG = 8'h8F;
  localparam logic [7:0] RCC_ADDR_CAUSE = 8'hA1;
  localparam logic [7:0] RCC_ADDR_SOFT_RESET_REG = 8'hE7;
  localparam logic [7:0] RCC_ADDR_KEY = 8'hF7;
  // reset values
  localparam logic [7:0] RCC_RST_CAUSE = 8'h00;
  localparam logic [7:0] RCC_RST_SOFT_RESET_REG = 8'h00;
  localparam logic [7:0] RCC_RST_KEY = 8'h00;
  localparam logic RCC_RST_ONE_CLK = 1'b0;
  // unlock bytes and the trigger value
  localparam logic [7:0] RCC_KEY_1 = 8'h55;
  localparam logic [7:0] RCC_KEY_2 = 8'hAA;
  localparam logic [7:0] RCC_KEY_3 = 8'h5A;
  localparam logic [7:0] RCC_SOFT_FIRE = 8'hFF;
  // field positions
  localparam int unsigned RCC_BIT_PAD = 4;
  localparam int unsigned RCC_BIT_WDT = 3;
  localparam int unsigned RCC_BIT_SOFT = 2;
  localparam int unsigned RCC_BIT_LVR = 1;
  localparam int unsigned RCC_BIT_POR = 0;
  localparam int unsigned RCC_BIT_ONE_CLK = 7;
  // normal clock source selection
  typedef enum logic [2:0] {
    RCC_CLK_XTAL = 3'b000, RCC_CLK_EXT_OSC = 3'b001, RCC_CLK_IRC_DIV1 = 3'b010,
    RCC_CLK_IRC_DIV2 = 3'b011, RCC_CLK_IRC_DIV4 = 3'b100, RCC_CLK_IRC_DIV8 = 3'b101,
    RCC_CLK_IRC_DIV16 = 3'b110
  } rcc_clk_src_type;
  // internal reset duration selection
  typedef enum logic [2:0] {
    RCC_RT_25MS = 3'b000, RCC_RT_200MS = 3'b001, RCC_RT_100MS = 3'b010,
    RCC_RT_50MS = 3'b011, RCC_RT_16MS = 3'b100, RCC_RT_8MS = 3'b101, RCC_RT_4MS = 3'b110
  } rcc_rst_time_type;
  // reset sequence states
  typedef enum logic [1:0] {
    RCC_SEQ_RUN = 2'b00, RCC_SEQ_HOLD = 2'b01, RCC_SEQ_STRETCH = 2'b10
  } rcc_seq_type;
  // unlock sequence states
  typedef enum logic [1:0] {
    RCC_KEY_IDLE = 2'b00, RCC_KEY_GOT1 = 2'b01, RCC_KEY_GOT2 = 2'b10, RCC_KEY_OPEN = 2'b11
  } rcc_key_state_type;
  // core side register access
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } rcc_sfr_req_type;
  // hardware reset sources, active high levels
  typedef struct packed {
    logic pad;
    logic wdt;
    logic low_voltage_reset;
    logic por;
  } rcc_src_type;
endpackage : rcc_pkg

// File: core/rcc_duration_timer.sv
`timescale 1ns/1ps
module rcc_duration_timer import rcc_pkg::*; (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic abort,
  input wire logic [RCC_CNT_W-1:0] load_val,
  output logic busy,
  output logic done
);
  // counter and running flag
  typedef struct packed {
    logic [RCC_CNT_W-1:0] cnt;
    logic busy;
  } rcc_tmr_state_type;
  rcc_tmr_state_type st;
  rcc_tmr_state_type next_st;

  // count down to one, done on the last counted cycle
  always_comb begin
    next_st = st;
    if (load) begin
      next_st.cnt = load_val;
      next_st.busy = 1'b1;
    end else if (abort) begin
      next_st.busy = 1'b0;
    end else if (st.busy) begin
      next_st.cnt = st.cnt - 1'b1;
      if (st.cnt == {{(RCC_CNT_W-1){1'b0}}, 1'b1}) begin
        next_st.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy = st.busy;
  assign done = st.busy && !load && !abort && (st.cnt == {{(RCC_CNT_W-1){1'b0}}, 1'b1});

  // RQ13 timer runs after a load
  chk_timer_load_run: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ13
    load && load_val > 2 |=> busy && !done ##1 (busy || $past(abort)))
    else $error("timer did not run after load");
endmodule : rcc_duration_timer

// File: core/rcc_mcycle_gen.sv
`timescale 1ns/1ps
module rcc_mcycle_gen import rcc_pkg::*; (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic one_clk_req,
  output logic one_clk_mode,
  output logic mcycle_strobe
);
  // phase of a two-clock cycle and the active mode
  typedef struct packed {
    logic phase;
    logic one_clk;
  } rcc_mc_state_type;
  rcc_mc_state_type st;
  rcc_mc_state_type next_st;

  // RQ14 cycle length per mode
  assign mcycle_strobe = st.one_clk | st.phase;
  assign one_clk_mode = st.one_clk;

  // mode only changes on a cycle boundary, so a running instruction keeps its timing
  always_comb begin
    next_st = st;
    next_st.phase = st.one_clk ? 1'b0 : ~st.phase;
    // RQ19 switch at boundary
    if (mcycle_strobe) begin
      next_st.one_clk = one_clk_req;
      next_st.phase = 1'b0;
    end
  end

  // RQ15 two-clock after reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= {1'b0, RCC_RST_ONE_CLK};
    end else begin
      st <= next_st;
    end
  end

  default clocking mc_clk @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_two_clk_len: assert property (!one_clk_mode && mcycle_strobe && !one_clk_req |=> // RQ14
    !mcycle_strobe)
    else $error("two-clock cycle shorter than two clocks");
  chk_mode_at_edge: assert property (!mcycle_strobe |=> $stable(one_clk_mode)) // RQ19
    else $error("mode changed inside a machine cycle");
  chk_mode_after_rst: assert property ($fell(sys_rst) |-> !one_clk_mode) // RQ15
    else $error("not in two-clock mode after reset");
endmodule : rcc_mcycle_gen

// File: core/rcc_reset_clock_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - soft reset writable only after 55,AA,5A
// RQ2 - writing FF when writable resets chip
// RQ3 - values 00 to FE do nothing
// RQ4 - software request ORed with hardware sources
// RQ5 - soft reset register clears at end
// RQ6 - software unlocks then writes FF
// RQ7 - pad reset sets bit 4
// RQ8 - watchdog reset sets bit 3
// RQ9 - software reset sets bit 2
// RQ10 - low-voltage reset sets bit 1
// RQ11 - power-on sets bit 0, 7:5 unused
// RQ12 - flags sticky until software clears
// RQ13 - reset duration selectable, 25 ms default
// RQ14 - machine cycle two or one clocks
// RQ15 - two-clock after reset, bit 7 selects one
// RQ16 - internal oscillator during initialization stage
// RQ17 - normal clock source selectable, div1 default
// RQ18 - wrong key byte restarts unlock
// RQ19 - mode change at next machine cycle
module rcc_reset_clock_ctrl import rcc_pkg::*; #(
  parameter int unsigned CYC_25MS = RCC_CYC_25MS,
  parameter int unsigned CYC_200MS = RCC_CYC_200MS,
  parameter int unsigned CYC_100MS = RCC_CYC_100MS,
  parameter int unsigned CYC_50MS = RCC_CYC_50MS,
  parameter int unsigned CYC_16MS = RCC_CYC_16MS,
  parameter int unsigned CYC_8MS = RCC_CYC_8MS,
  parameter int unsigned CYC_4MS = RCC_CYC_4MS
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire rcc_sfr_req_type sfr_req,
  output logic [7:0] sfr_rdata,
  input wire rcc_src_type hw_src,
  input wire rcc_rst_time_type rst_time_sel,
  input wire rcc_clk_src_type clk_src_sel,
  output logic chip_rst,
  output rcc_clk_src_type sys_clk_sel,
  output logic one_clk_mode,
  output logic mcycle_strobe,
  output logic soft_unlocked
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    rcc_seq_type seq;          // reset sequence position
    rcc_key_state_type unlock; // unlock progress
    logic [7:0] key;           // last byte written to the key register
    logic [7:0] soft_reset_reg;         // soft reset register
    logic [4:0] cause;         // sticky reset cause flags
    logic one_clk;             // interface control bit 7
    logic [7:0] rdata;         // registered read data
    rcc_clk_src_type clk_sel;  // clock source handed to the clock tree
  } rcc_top_state_type;
  rcc_top_state_type st;
  rcc_top_state_type next_st;

  logic any_hw;          // any hardware source asserted
  logic core_live;       // core out of reset, its writes count
  logic wr_key;          // write to the key register
  logic wr_soft_reset_reg;        // write to the soft reset register
  logic wr_cause;        // write to the cause register
  logic wr_interface_ctrl_reg;        // write to interface control
  logic soft_fire;       // accepted FF write
  logic tmr_load;        // start the duration count
  logic tmr_done;        // duration elapsed
  logic tmr_busy;        // duration running
  logic [RCC_CNT_W-1:0] dur_cyc; // selected duration in cycles

  ////////////////////////////////////////////////////////////////////////////
  // decode
  ////////////////////////////////////////////////////////////////////////////
  assign any_hw = hw_src.pad | hw_src.wdt | hw_src.low_voltage_reset | hw_src.por;
  // the core is held in reset, so its writes are ignored until the sequence ends
  assign core_live = (st.seq == RCC_SEQ_RUN) && !any_hw;
  assign wr_key = core_live && sfr_req.wr && (sfr_req.addr == RCC_ADDR_KEY);
  assign wr_soft_reset_reg = core_live && sfr_req.wr && (sfr_req.addr == RCC_ADDR_SOFT_RESET_REG);
  assign wr_cause = core_live && sfr_req.wr && (sfr_req.addr == RCC_ADDR_CAUSE);
  assign wr_interface_ctrl_reg = core_live && sfr_req.wr && (sfr_req.addr == RCC_ADDR_INTERFACE_CTRL_REG);
  // RQ2 trigger on FF, RQ3 other values do nothing
  assign soft_fire = wr_soft_reset_reg && (st.unlock == RCC_KEY_OPEN) && (sfr_req.wdata == RCC_SOFT_FIRE);

  // duration table, unused code falls back to the default
  // RQ13 duration select
  always_comb begin
    case (rst_time_sel)
      RCC_RT_200MS: dur_cyc = RCC_CNT_W'(CYC_200MS);
      RCC_RT_100MS: dur_cyc = RCC_CNT_W'(CYC_100MS);
      RCC_RT_50MS: dur_cyc = RCC_CNT_W'(CYC_50MS);
      RCC_RT_16MS: dur_cyc = RCC_CNT_W'(CYC_16MS);
      RCC_RT_8MS: dur_cyc = RCC_CNT_W'(CYC_8MS);
      RCC_RT_4MS: dur_cyc = RCC_CNT_W'(CYC_4MS);
      default: dur_cyc = RCC_CNT_W'(CYC_25MS);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    tmr_load = 1'b0;

    // reset sequence: hold while sources stand, then stretch
    case (st.seq)
      RCC_SEQ_RUN: begin
        if (any_hw) begin
          next_st.seq = RCC_SEQ_HOLD;
        end else if (soft_fire) begin
          // RQ4 soft request joins the chip reset
          next_st.seq = RCC_SEQ_STRETCH;
          tmr_load = 1'b1;
        end
      end
      RCC_SEQ_HOLD: begin
        if (!any_hw) begin
          next_st.seq = RCC_SEQ_STRETCH;
          tmr_load = 1'b1;
        end
      end
      RCC_SEQ_STRETCH: begin
        // a new source during the stretch restarts the whole wait
        if (any_hw) begin
          next_st.seq = RCC_SEQ_HOLD;
        end else if (tmr_done) begin
          next_st.seq = RCC_SEQ_RUN;
          // RQ5 self-clear at the end
          next_st.soft_reset_reg = RCC_RST_SOFT_RESET_REG;
        end
      end
      default: begin
        next_st.seq = RCC_SEQ_HOLD;
      end
    endcase

    // unlock sequence, restarted by any byte out of order
    if (wr_key) begin
      next_st.key = sfr_req.wdata;
      // RQ18 wrong byte restarts
      next_st.unlock = (sfr_req.wdata == RCC_KEY_1) ? RCC_KEY_GOT1 : RCC_KEY_IDLE;
      // RQ1 exact order 55, AA, 5A
      case (st.unlock)
        RCC_KEY_GOT1: begin
          if (sfr_req.wdata == RCC_KEY_2) begin
            next_st.unlock = RCC_KEY_GOT2;
          end
        end
        RCC_KEY_GOT2: begin
          if (sfr_req.wdata == RCC_KEY_3) begin
            next_st.unlock = RCC_KEY_OPEN;
          end
        end
        default: begin
        end
      endcase
    end

    // RQ1 write only when open; one write uses up the unlock
    if (wr_soft_reset_reg && st.unlock == RCC_KEY_OPEN) begin
      next_st.soft_reset_reg = sfr_req.wdata;
      next_st.unlock = RCC_KEY_IDLE;
    end

    // interface control, only the mode bit is kept
    // RQ15 bit 7 requests one-clock mode
    if (wr_interface_ctrl_reg) begin
      next_st.one_clk = sfr_req.wdata[RCC_BIT_ONE_CLK];
    end

    // cause flags: writing zero clears a bit, ones leave it alone
    // RQ12 only software clears
    if (wr_cause) begin
      next_st.cause = st.cause & sfr_req.wdata[4:0];
    end
    // sets come after the clear so a coincident event wins
    // RQ7 pad flag
    if (hw_src.pad) begin
      next_st.cause[RCC_BIT_PAD] = 1'b1;
    end
    // RQ8 watchdog flag
    if (hw_src.wdt) begin
      next_st.cause[RCC_BIT_WDT] = 1'b1;
    end
    // RQ9 software flag
    if (soft_fire) begin
      next_st.cause[RCC_BIT_SOFT] = 1'b1;
    end
    // RQ10 low-voltage flag
    if (hw_src.low_voltage_reset) begin
      next_st.cause[RCC_BIT_LVR] = 1'b1;
    end
    // RQ11 power-on flag
    if (hw_src.por) begin
      next_st.cause[RCC_BIT_POR] = 1'b1;
    end

    // everything but the flags, the soft register and the read data falls back during reset
    if (next_st.seq != RCC_SEQ_RUN) begin
      next_st.unlock = RCC_KEY_IDLE;
      next_st.key = RCC_RST_KEY;
      next_st.one_clk = RCC_RST_ONE_CLK;
    end

    // clock source follows the reset sequence
    // RQ16 internal oscillator while initialising
    // RQ17 configured source afterwards
    next_st.clk_sel = (next_st.seq == RCC_SEQ_RUN) ? clk_src_sel : RCC_CLK_IRC_DIV1;

    // read data, bits 7:5 of the cause register read zero
    next_st.rdata = 8'h00;
    if (sfr_req.rd) begin
      case (sfr_req.addr)
        RCC_ADDR_CAUSE: next_st.rdata = {3'h0, st.cause};
        RCC_ADDR_SOFT_RESET_REG: next_st.rdata = st.soft_reset_reg;
        RCC_ADDR_KEY: next_st.rdata = st.key;
        RCC_ADDR_INTERFACE_CTRL_REG: next_st.rdata = {st.one_clk, 7'h00};
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  ////////////////////////////////////////////////////////////////////////////
  // block reset starts in hold, so every power-up runs a full stretch
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st.seq <= RCC_SEQ_HOLD;
      st.unlock <= RCC_KEY_IDLE;
      st.key <= RCC_RST_KEY;
      st.soft_reset_reg <= RCC_RST_SOFT_RESET_REG;
      st.cause <= RCC_RST_CAUSE[4:0];
      st.one_clk <= RCC_RST_ONE_CLK;
      st.rdata <= 8'h00;
      st.clk_sel <= RCC_CLK_IRC_DIV1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs and sub-blocks
  ////////////////////////////////////////////////////////////////////////////
  // RQ4 chip reset is the OR of all sources
  assign chip_rst = (st.seq != RCC_SEQ_RUN) | any_hw;
  assign sfr_rdata = st.rdata;
  assign sys_clk_sel = st.clk_sel;
  assign soft_unlocked = (st.unlock == RCC_KEY_OPEN);

  // duration counter for the stretch phase
  rcc_duration_timer u_timer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .abort(any_hw),
    .load_val(dur_cyc),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // machine cycle pacing, held in two-clock mode through chip reset
  rcc_mcycle_gen u_mcycle (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst | chip_rst),
    .one_clk_req(st.one_clk),
    .one_clk_mode(one_clk_mode),
    .mcycle_strobe(mcycle_strobe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  ////////////////////////////////////////////////////////////////////////////
  default clocking top_clk @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  chk_soft_reset_reg_locked: assert property (wr_soft_reset_reg && !soft_unlocked |=> $stable(st.soft_reset_reg)) // RQ1
    else $error("soft reset register written while locked");
  chk_unlock_cause: assert property ($rose(soft_unlocked) |-> // RQ1
    $past(wr_key) && $past(sfr_req.wdata) == RCC_KEY_3)
    else $error("unlocked without final key byte");
  chk_key_break: assert property (wr_key && st.unlock == RCC_KEY_GOT2 && // RQ18
    sfr_req.wdata != RCC_KEY_3 |=> !soft_unlocked)
    else $error("wrong key byte did not restart unlock");
  chk_soft_fire: assert property (soft_fire |=> chip_rst && st.cause[RCC_BIT_SOFT] // RQ2
    ##1 chip_rst)
    else $error("FF write did not reset chip");
  chk_soft_noop: assert property (wr_soft_reset_reg && sfr_req.wdata != RCC_SOFT_FIRE |=> // RQ3
    st.seq == RCC_SEQ_RUN)
    else $error("non-FF soft write caused reset");
  chk_src_or: assert property (any_hw |-> chip_rst) // RQ4
    else $error("hardware source not in chip reset");
  chk_soft_reset_reg_clear: assert property ($fell(chip_rst) |-> st.soft_reset_reg == RCC_RST_SOFT_RESET_REG) // RQ5
    else $error("soft reset register not cleared");
  chk_pad_flag: assert property (hw_src.pad |=> st.cause[RCC_BIT_PAD]) // RQ7
    else $error("pad flag not set");
  chk_wdt_flag: assert property (hw_src.wdt |=> st.cause[RCC_BIT_WDT]) // RQ8
    else $error("watchdog flag not set");
  chk_lvr_flag: assert property (hw_src.low_voltage_reset |=> st.cause[RCC_BIT_LVR]) // RQ10
    else $error("low-voltage flag not set");
  chk_por_flag: assert property (hw_src.por |=> st.cause[RCC_BIT_POR] ##1 chip_rst) // RQ11
    else $error("power-on flag not set");
  chk_flag_sticky: assert property (!wr_cause |=> // RQ12
    (st.cause & $past(st.cause)) == $past(st.cause))
    else $error("cause flag lost without clear");
  chk_init_clock: assert property (chip_rst && !any_hw |-> // RQ16
    sys_clk_sel == RCC_CLK_IRC_DIV1)
    else $error("init clock not internal oscillator");
  // the source is registered, so it follows last cycle's choice
  chk_norm_clock: assert property (!chip_rst |-> sys_clk_sel == $past(clk_src_sel)) // RQ17
    else $error("normal clock not the configured source");
  chk_stretch_hold: assert property (tmr_load |=> chip_rst [*3]) // RQ13
    else $error("reset stretch ended early");
  // RQ13 timer runs in stretch
  chk_stretch_timer: assert property (st.seq == RCC_SEQ_STRETCH |-> tmr_busy) // RQ13
    else $error("stretch running without duration count");
  // RQ9 soft flag source
  chk_soft_flag_src: assert property ($rose(st.cause[RCC_BIT_SOFT]) |-> // RQ9
    $past(soft_fire))
    else $error("software flag set without software reset");
  // RQ11 upper bits read zero
  chk_cause_unused: assert property (sfr_req.rd && sfr_req.addr == RCC_ADDR_CAUSE |=> // RQ11
    sfr_rdata[7:5] == 3'h0)
    else $error("unused cause bits not zero");
  // RQ1 reset relocks key
  chk_relock_rst: assert property (chip_rst |=> !soft_unlocked) // RQ1
    else $error("unlock survived chip reset");
  // RQ1 one write uses unlock
  chk_unlock_spent: assert property (wr_soft_reset_reg |=> !soft_unlocked) // RQ1
    else $error("unlock not spent by soft register write");
  // RQ15 reset gives two-clock
  chk_mode_in_rst: assert property (chip_rst |=> !one_clk_mode) // RQ15
    else $error("one-clock mode kept through chip reset");
endmodule : rcc_reset_clock_ctrl

// File: verification/test_reset_and_clock_control.sv
`timescale 1ns/1ps
module test_reset_and_clock_control import rcc_pkg::*;;
  // shortened durations, indexed by the duration select code
  localparam int unsigned DUR [8] = '{40, 90, 70, 50, 30, 25, 20, 40};
  logic clk_sys; // bench clock, 40 ns
  logic sys_rst; // block reset
  rcc_sfr_req_type sfr_req; // core side access
  logic [7:0] sfr_rdata;
  rcc_src_type hw_src; // hardware sources
  rcc_rst_time_type rst_time_sel;
  rcc_clk_src_type clk_src_sel;
  logic chip_rst;
  rcc_clk_src_type sys_clk_sel;
  logic one_clk_mode;
  logic mcycle_strobe;
  logic soft_unlocked;
  int errors; // mismatches
  int checks_done; // comparisons
  int cycles; // hang guard
  logic [7:0] m_cause; // model of the cause flags
  logic [7:0] rd_val;
  int bit_of [4] = '{RCC_BIT_POR, RCC_BIT_LVR, RCC_BIT_WDT, RCC_BIT_PAD};
  ////////////////////////////////////////////////////////////////////////////
  rcc_reset_clock_ctrl #(.CYC_25MS(DUR[0]), .CYC_200MS(DUR[1]), .CYC_100MS(DUR[2]),
    .CYC_50MS(DUR[3]), .CYC_16MS(DUR[4]), .CYC_8MS(DUR[5]), .CYC_4MS(DUR[6]))
    u_rcc_reset_clock_ctrl (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .hw_src(hw_src), .rst_time_sel(rst_time_sel), .clk_src_sel(clk_src_sel),
    .chip_rst(chip_rst), .sys_clk_sel(sys_clk_sel), .one_clk_mode(one_clk_mode),
    .mcycle_strobe(mcycle_strobe), .soft_unlocked(soft_unlocked));
  ////////////////////////////////////////////////////////////////////////////
  // free running clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // hang guard, well above the expected run of under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("BAD %0t timeout", $time);
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  // one comparison, four-state
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  // one write, strobe held over one rising edge
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_req.addr = a;
    sfr_req.wdata = d;
    sfr_req.wr = 1'b1;
    @(negedge clk_sys);
    sfr_req.wr = 1'b0;
  endtask : sfr_wr
  // one read, data taken the cycle after the strobe
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    sfr_req.addr = a;
    sfr_req.rd = 1'b1;
    @(negedge clk_sys);
    d = sfr_rdata;
    sfr_req.rd = 1'b0;
  endtask : sfr_rd
  task automatic unlock;
    sfr_wr(RCC_ADDR_KEY, RCC_KEY_1);
    sfr_wr(RCC_ADDR_KEY, RCC_KEY_2);
    sfr_wr(RCC_ADDR_KEY, RCC_KEY_3);
  endtask : unlock
  // counts cycles of chip reset, bounded, then checks the length
  task automatic wait_run(input int extra);
    int n;
    n = extra;
    while (chip_rst !== 1'b0 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    checks_done++;
    if (n < DUR[rst_time_sel] || n > DUR[rst_time_sel] + 2) begin
      errors++;
      $display("BAD %0t reset length %0d sel %0d", $time, n, rst_time_sel);
    end
  endtask : wait_run
  // one reset from source k: 0 por, 1 lvr, 2 wdt, 3 pad, 4 software
  task automatic fire(input int k);
    int hold;
    if (k == 4) begin
      unlock();
      check(8'(soft_unlocked), 8'h01, "unlocked");
      sfr_wr(RCC_ADDR_SOFT_RESET_REG, RCC_SOFT_FIRE);
      m_cause[RCC_BIT_SOFT] = 1'b1;
    end else begin
      hold = $urandom_range(4, 1);
      @(negedge clk_sys);
      hw_src = rcc_src_type'(4'h1 << k);
      repeat (hold) @(negedge clk_sys);
      hw_src = '0;
      m_cause[bit_of[k]] = 1'b1;
    end
    check(8'(chip_rst), 8'h01, "chip reset");
    @(negedge clk_sys);
    check(8'(sys_clk_sel), 8'(RCC_CLK_IRC_DIV1), "init clock");
    wait_run(1);
    check(8'(sys_clk_sel), 8'(clk_src_sel), "normal clock");
    sfr_rd(RCC_ADDR_CAUSE, rd_val);
    check(rd_val, m_cause, "cause");
    sfr_rd(RCC_ADDR_SOFT_RESET_REG, rd_val);
    check(rd_val, 8'h00, "soft reg cleared");
  endtask : fire
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int cnt;
    logic [7:0] r;
    logic [7:0] bad_seq [2][4];
    sys_rst = 1'b1;
    sfr_req = '0;
    hw_src = '0;
    rst_time_sel = RCC_RT_25MS;
    clk_src_sel = RCC_CLK_IRC_DIV4;
    m_cause = 8'h00;
    void'($urandom(63714));
    repeat (20) @(negedge clk_sys);
    check(8'(sys_clk_sel), 8'(RCC_CLK_IRC_DIV1), "clock in reset");
    sys_rst = 1'b0;
    wait_run(0);
    check(8'(one_clk_mode), 8'h00, "two clock default");
    check(8'(sys_clk_sel), 8'(RCC_CLK_IRC_DIV4), "normal clock");
    sfr_rd(RCC_ADDR_CAUSE, rd_val);
    check(rd_val, RCC_RST_CAUSE, "cause reset");
    sfr_rd(RCC_ADDR_SOFT_RESET_REG, rd_val);
    check(rd_val, RCC_RST_SOFT_RESET_REG, "soft reset value");
    sfr_rd(RCC_ADDR_KEY, rd_val);
    check(rd_val, RCC_RST_KEY, "key reset value");
    $display("test reset values done");
    sfr_wr(RCC_ADDR_SOFT_RESET_REG, RCC_SOFT_FIRE);
    repeat (3) @(negedge clk_sys);
    check(8'(chip_rst), 8'h00, "locked write");
    r = 8'h00;
    bad_seq[0] = '{RCC_KEY_1, RCC_KEY_2, r, RCC_KEY_3};
    bad_seq[1] = '{RCC_KEY_1, r, RCC_KEY_2, RCC_KEY_3};
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 4; i++) begin
        sfr_wr(RCC_ADDR_KEY, bad_seq[s][i]);
      end
      check(8'(soft_unlocked), 8'h00, "broken order");
      sfr_wr(RCC_ADDR_SOFT_RESET_REG, RCC_SOFT_FIRE);
      repeat (2) @(negedge clk_sys);
      check(8'(chip_rst), 8'h00, "broken order write");
    end
    sfr_rd(RCC_ADDR_KEY, rd_val);
    check(rd_val, RCC_KEY_3, "key readback");
    for (int i = 0; i < 3; i++) begin
      r = (i == 0) ? 8'h00 : (i == 1) ? 8'hFE : 8'($urandom_range(254, 0));
      unlock();
      check(8'(soft_unlocked), 8'h01, "unlocked");
      sfr_wr(RCC_ADDR_SOFT_RESET_REG, r);
      repeat (3) @(negedge clk_sys);
      check(8'(chip_rst), 8'h00, "no action value");
    end
    $display("test soft reset guard done");
    // every duration code, every source, sticky flags
    for (int k = 0; k < 10; k++) begin
      @(negedge clk_sys);
      rst_time_sel = rcc_rst_time_type'(3'(k));
      clk_src_sel = rcc_clk_src_type'(3'($urandom_range(6, 0)));
      fire(k % 5);
      if (k % 3 == 2) begin
        r = 8'($urandom);
        sfr_wr(RCC_ADDR_CAUSE, r);
        m_cause = m_cause & r;
        sfr_rd(RCC_ADDR_CAUSE, rd_val);
        check(rd_val, m_cause, "cause clear");
      end
    end
    $display("test reset sources done");
    for (int m = 1; m >= 0; m--) begin
      r = 8'($urandom_range(127, 0));
      sfr_wr(RCC_ADDR_INTERFACE_CTRL_REG, (m == 1) ? (r | 8'h80) : r);
      sfr_rd(RCC_ADDR_INTERFACE_CTRL_REG, rd_val);
      check(rd_val, (m == 1) ? 8'h80 : 8'h00, "mode bit");
      repeat (2) @(negedge clk_sys);
      check(8'(one_clk_mode), 8'(m), "mode");
      cnt = 0;
      repeat (8) begin
        @(negedge clk_sys);
        cnt += int'(mcycle_strobe === 1'b1);
      end
      check(8'(cnt), (m == 1) ? 8'h08 : 8'h04, "strobes");
    end
    sfr_wr(RCC_ADDR_INTERFACE_CTRL_REG, 8'h80);
    fire(3);
    check(8'(one_clk_mode), 8'h00, "mode after reset");
    $display("test machine cycle done");
    // unmapped address reads zero
    do r = 8'($urandom);
    while (r == RCC_ADDR_INTERFACE_CTRL_REG || r == RCC_ADDR_CAUSE || r == RCC_ADDR_SOFT_RESET_REG ||
      r == RCC_ADDR_KEY);
    sfr_rd(r, rd_val);
    check(rd_val, 8'h00, "unmapped read");
    $display("test unmapped done");
    test_done();
  end
endmodule : test_reset_and_clock_control
